// ---- rtl/dtc_dual_timer_control.sv ----
/*
  dtc_dual_timer_control: control registers and control logic of a 16-bit
  wide timer and an 8-bit carrier timer, reached over AHB-Lite.
  Assumes the counting datapaths sit outside and report time-out, capture
  and edge events as one-cycle pulses on sys_clk.
*/
// Operation
// - the wide timer counts at sys_clk divided by 1, 2, 4 or 8 per a two-bit field.
// - the prescale field keeps its value across stop-mode recovery.
// - a demodulation capture raises the wide timer interrupt only with the capture mask set.
// - a wide timer time-out raises the interrupt only with the time-out mask set.
// - one write setting both shared enables starts both timers on the same edge.
// - the wide timer runs while either of its two enable bits is 1.
// - the carrier timer runs while its shared enable or its own control bit 7 is 1.
// - in sync mode the first carrier pulse is aligned to the rise of the demodulated signal.
// - with toggle freeze set the wide output holds its level while interrupts go on.
// - single-cycle capture goes active on edge 3, captures on 4 and 5, interrupts on 5.
// - in single-cycle capture a carrier time-out clears the edge count to 0.
// - the three low shared bits always read as ones and writes to them are ignored.
// - capture mask, sync, freeze and single-cycle bits survive stop-mode recovery.
// - time-out sets a flag that a write of 1 clears and a write of 0 leaves alone.
`timescale 1ns/1ps
`default_nettype none

module dtc_dual_timer_control #(
  parameter int COUNT_W = 3
) (
  input  wire logic        sys_clk,        // system clock, 50 MHz
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready
  output logic             hreadyout,      // slave ready
  output logic [31:0]      hrdata,         // read data
  output logic             hresp,          // always OKAY
  input  wire logic        stopRecovery,   // stop-mode recovery pulse
  input  wire logic        timeoutEvent,   // wide timer terminal count pulse
  input  wire logic        captureEvent,   // wide timer capture pulse
  input  wire logic        demodMode,      // wide timer in demodulation mode
  input  wire logic        carrierCtlRun,  // carrier_timer_control bit 7
  input  wire logic        carrierEdge,    // carrier input edge pulse
  input  wire logic        carrierTimeout, // carrier time-out pulse
  input  wire logic        demodSignal,    // demodulated signal level
  input  wire logic        portDataLatch,  // ordinary port data
  output logic             wideTimerRun,   // wide timer enabled
  output logic             carrierTimerRun,// carrier timer enabled
  output logic             wideCountEn,    // wide timer count enable pulse
  output logic             singlePass,     // single/modulo-n select
  output logic             wideTimerIrq,   // wide timer interrupt pulse
  output logic             wideTimerOut,   // wide timer output level
  output logic             port3Pin5,      // port 3 pin 5 output level
  output logic             carrierGate,    // carrier may produce pulses
  output logic             carrierActive,  // carrier capture active
  output logic             carrierCapture, // carrier capture pulse
  output logic             carrierIrq      // carrier interrupt pulse
);

  if (COUNT_W < 3) begin
    $error("dtc_dual_timer_control needs COUNT_W of at least 3");
  end

  localparam logic [COUNT_W-1:0] ACTIVE_CNT = COUNT_W'(dtc_pkg::ACTIVE_EDGE);
  localparam logic [COUNT_W-1:0] FIRST_CNT  = COUNT_W'(dtc_pkg::FIRST_CAPTURE_EDGE);
  localparam logic [COUNT_W-1:0] LAST_CNT   = COUNT_W'(dtc_pkg::LAST_CAPTURE_EDGE);

  // bus data-phase state
  logic             wrPhase_reg;
  logic             wrPhase_next;
  logic [1:0]       wrSel_reg;
  logic [1:0]       wrSel_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  // control registers; bit 5 of the wide register is the time-out flag
  logic [7:0]       wideCtrl_reg;
  logic [7:0]       wideCtrl_next;
  logic [4:0]       sharedCtrl_reg;
  logic [4:0]       sharedCtrl_next;
  // event logic
  logic             wideOut_reg;
  logic             wideOut_next;
  logic             wideIrq_reg;
  logic             wideIrq_next;
  logic [COUNT_W-1:0] edgeCount_reg;
  logic [COUNT_W-1:0] edgeCount_next;
  logic             capture_reg;
  logic             capture_next;
  logic             carrierIrq_reg;
  logic             carrierIrq_next;
  logic             demodPrev_reg;
  dtc_pkg::dtc_sync_type syncState_reg;
  dtc_pkg::dtc_sync_type syncState_next;

  logic             addrPhase;
  logic [1:0]       addrSel;
  logic             tickEn;
  logic             wideRunNext;
  logic             carrierRunNext;
  logic [COUNT_W-1:0] edgeNum;

  // address decode: 1 wide control, 2 shared control, 3 status, 0 unmapped
  always_comb begin
    addrPhase = hsel && hready && (htrans == dtc_pkg::HTRANS_NONSEQ);
    case (haddr)
      dtc_pkg::WIDE_CTRL_ADDR:   addrSel = 2'h1;
      dtc_pkg::SHARED_CTRL_ADDR: addrSel = 2'h2;
      dtc_pkg::STATUS_ADDR:      addrSel = 2'h3;
      default:                   addrSel = 2'h0;
    endcase
  end

  // control register next values: bus write, then recovery, then hardware set
  always_comb begin
    wideCtrl_next   = wideCtrl_reg;
    sharedCtrl_next = sharedCtrl_reg;
    if (wrPhase_reg && wrSel_reg == 2'h1) begin
      wideCtrl_next = hwdata[7:0];
      wideCtrl_next[dtc_pkg::TIMEOUT_BIT] = wideCtrl_reg[dtc_pkg::TIMEOUT_BIT]
                                            && !hwdata[dtc_pkg::TIMEOUT_BIT];
    end
    if (wrPhase_reg && wrSel_reg == 2'h2) begin
      sharedCtrl_next = hwdata[7:3];
    end
    if (stopRecovery) begin
      // only the enables, mode, flag, time-out mask and pin select are reset
      wideCtrl_next[dtc_pkg::WIDE_RUN_BIT]    = dtc_pkg::WIDE_CTRL_RESET[dtc_pkg::WIDE_RUN_BIT];
      wideCtrl_next[dtc_pkg::SINGLE_PASS_BIT] = dtc_pkg::WIDE_CTRL_RESET[dtc_pkg::SINGLE_PASS_BIT];
      wideCtrl_next[dtc_pkg::TIMEOUT_BIT]     = dtc_pkg::WIDE_CTRL_RESET[dtc_pkg::TIMEOUT_BIT];
      wideCtrl_next[dtc_pkg::COUNT_MASK_BIT] = dtc_pkg::WIDE_CTRL_RESET[dtc_pkg::COUNT_MASK_BIT];
      wideCtrl_next[dtc_pkg::PIN_SELECT_BIT] = dtc_pkg::WIDE_CTRL_RESET[dtc_pkg::PIN_SELECT_BIT];
      sharedCtrl_next[dtc_pkg::SH_WIDE_RUN_BIT-3]    =
        dtc_pkg::SHARED_CTRL_RESET[dtc_pkg::SH_WIDE_RUN_BIT-3];
      sharedCtrl_next[dtc_pkg::SH_CARRIER_RUN_BIT-3] =
        dtc_pkg::SHARED_CTRL_RESET[dtc_pkg::SH_CARRIER_RUN_BIT-3];
    end
    // a time-out in the clearing cycle still leaves the flag set
    if (timeoutEvent) begin
      wideCtrl_next[dtc_pkg::TIMEOUT_BIT] = 1'b1;
    end
  end

  assign wideRunNext    = wideCtrl_next[dtc_pkg::WIDE_RUN_BIT]
                          || sharedCtrl_next[dtc_pkg::SH_WIDE_RUN_BIT-3];
  assign carrierRunNext = carrierCtlRun || sharedCtrl_next[dtc_pkg::SH_CARRIER_RUN_BIT-3];

  // bus next values; read data is built from next register values so a
  // read straight after a write sees the written value with no wait state
  always_comb begin
    wrPhase_next = addrPhase && hwrite;
    wrSel_next   = addrSel;
    rdata_next   = rdata_reg;
    if (addrPhase && !hwrite) begin
      case (addrSel)
        2'h1:    rdata_next = {24'h000000, wideCtrl_next};
        2'h2:    rdata_next = {24'h000000, sharedCtrl_next, dtc_pkg::SH_RESERVED_ONES};
        2'h3:    rdata_next = {24'h000000, 1'b0, carrierActive, carrierGate, wideOut_reg,
                               wideRunNext, carrierRunNext, 2'h0};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPhase_reg    <= 1'b0;
      wrSel_reg      <= 2'h0;
      rdata_reg      <= 32'h00000000;
      wideCtrl_reg   <= dtc_pkg::WIDE_CTRL_RESET;
      sharedCtrl_reg <= dtc_pkg::SHARED_CTRL_RESET;
    end else begin
      wrPhase_reg    <= wrPhase_next;
      wrSel_reg      <= wrSel_next;
      rdata_reg      <= rdata_next;
      wideCtrl_reg   <= wideCtrl_next;
      sharedCtrl_reg <= sharedCtrl_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // timer run enables, wide timer mode and rate
  assign wideTimerRun    = wideCtrl_reg[dtc_pkg::WIDE_RUN_BIT]
                           || sharedCtrl_reg[dtc_pkg::SH_WIDE_RUN_BIT-3];
  assign carrierTimerRun = carrierCtlRun
                           || sharedCtrl_reg[dtc_pkg::SH_CARRIER_RUN_BIT-3];
  assign singlePass      = wideCtrl_reg[dtc_pkg::SINGLE_PASS_BIT];

  dtc_prescaler #(
    .DIV_WIDTH (3)
  ) u_prescaler (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sel     (dtc_pkg::dtc_prescale_type'(
                wideCtrl_reg[dtc_pkg::PRESCALE_MSB:dtc_pkg::PRESCALE_LSB])),
    .tickEn  (tickEn)
  );

  assign wideCountEn = tickEn && wideTimerRun;

  // wide timer output toggle and interrupt request
  always_comb begin
    wideOut_next = wideOut_reg;
    if (timeoutEvent && wideTimerRun && !sharedCtrl_reg[dtc_pkg::SH_FREEZE_BIT-3]) begin
      wideOut_next = !wideOut_reg;
    end
    wideIrq_next = (timeoutEvent && wideCtrl_reg[dtc_pkg::COUNT_MASK_BIT])
                   || (captureEvent && demodMode
                       && wideCtrl_reg[dtc_pkg::CAPTURE_MASK_BIT]);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wideOut_reg <= 1'b0;
      wideIrq_reg <= 1'b0;
    end else begin
      wideOut_reg <= wideOut_next;
      wideIrq_reg <= wideIrq_next;
    end
  end

  assign wideTimerOut = wideOut_reg;
  assign wideTimerIrq = wideIrq_reg;
  assign port3Pin5    = wideCtrl_reg[dtc_pkg::PIN_SELECT_BIT] ? wideOut_reg
                                                              : portDataLatch;

  // carrier edge counting; in single-cycle mode edges past the fifth are ignored until a time-out
  always_comb begin
    edgeNum         = edgeCount_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
    edgeCount_next  = edgeCount_reg;
    capture_next    = 1'b0;
    carrierIrq_next = 1'b0;
    if (sharedCtrl_reg[dtc_pkg::SH_SINGLE_BIT-3]) begin
      if (carrierTimeout) begin
        edgeCount_next = {COUNT_W{1'b0}};
      end else if (carrierEdge && carrierTimerRun && edgeCount_reg < LAST_CNT) begin
        edgeCount_next  = edgeNum;
        capture_next    = (edgeNum >= FIRST_CNT);
        carrierIrq_next = (edgeNum == LAST_CNT);
      end
    end else begin
      edgeCount_next  = {COUNT_W{1'b0}};
      capture_next    = carrierEdge && carrierTimerRun;
      carrierIrq_next = carrierEdge && carrierTimerRun;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edgeCount_reg  <= {COUNT_W{1'b0}};
      capture_reg    <= 1'b0;
      carrierIrq_reg <= 1'b0;
    end else begin
      edgeCount_reg  <= edgeCount_next;
      capture_reg    <= capture_next;
      carrierIrq_reg <= carrierIrq_next;
    end
  end

  assign carrierCapture = capture_reg;
  assign carrierIrq     = carrierIrq_reg;
  assign carrierActive  = sharedCtrl_reg[dtc_pkg::SH_SINGLE_BIT-3]
                          ? (edgeCount_reg >= ACTIVE_CNT) : carrierTimerRun;

  // carrier start alignment; waiting for a rise avoids a clipped first pulse
  always_comb begin
    syncState_next = syncState_reg;
    case (syncState_reg)
      dtc_pkg::SYNC_IDLE: begin
        if (carrierTimerRun) begin
          syncState_next = sharedCtrl_reg[dtc_pkg::SH_SYNC_BIT-3] ? dtc_pkg::SYNC_WAIT
                                                                  : dtc_pkg::SYNC_RUN;
        end
      end
      dtc_pkg::SYNC_WAIT: begin
        if (!carrierTimerRun) begin
          syncState_next = dtc_pkg::SYNC_IDLE;
        end else if ((demodSignal && !demodPrev_reg)
                     || !sharedCtrl_reg[dtc_pkg::SH_SYNC_BIT-3]) begin
          syncState_next = dtc_pkg::SYNC_RUN;
        end
      end
      dtc_pkg::SYNC_RUN: begin
        if (!carrierTimerRun) begin
          syncState_next = dtc_pkg::SYNC_IDLE;
        end else if (sharedCtrl_reg[dtc_pkg::SH_SYNC_BIT-3] && !demodSignal) begin
          syncState_next = dtc_pkg::SYNC_WAIT;
        end
      end
      default: syncState_next = dtc_pkg::SYNC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncState_reg <= dtc_pkg::SYNC_IDLE;
      demodPrev_reg <= 1'b0;
    end else begin
      syncState_reg <= syncState_next;
      demodPrev_reg <= demodSignal;
    end
  end

  assign carrierGate = (syncState_reg == dtc_pkg::SYNC_RUN);

endmodule

`default_nettype wire

// ---- rtl/dtc_pkg.sv ----
/*
  dtc_pkg: shared constants for the dual timer control block: register
  indices and byte addresses, field positions, reset values, prescale
  codes and the edge numbers of single-cycle capture.
  Assumes one 32-bit bus with one register per aligned word.
*/
package dtc_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [11:0] WIDE_CTRL_INDEX   = 12'hD02;
  localparam logic [11:0] SHARED_CTRL_INDEX = 12'hD03;
  localparam logic [11:0] STATUS_INDEX      = 12'hD04;
  localparam logic [31:0] WIDE_CTRL_ADDR    = {18'h00000, WIDE_CTRL_INDEX, 2'h0};
  localparam logic [31:0] SHARED_CTRL_ADDR  = {18'h00000, SHARED_CTRL_INDEX, 2'h0};
  localparam logic [31:0] STATUS_ADDR       = {18'h00000, STATUS_INDEX, 2'h0};

  // wide_timer_control fields
  localparam int WIDE_RUN_BIT     = 7;
  localparam int SINGLE_PASS_BIT  = 6;
  localparam int TIMEOUT_BIT      = 5;
  localparam int PRESCALE_MSB     = 4;
  localparam int PRESCALE_LSB     = 3;
  localparam int CAPTURE_MASK_BIT = 2;
  localparam int COUNT_MASK_BIT   = 1;
  localparam int PIN_SELECT_BIT   = 0;

  // timer_shared_control fields
  localparam int SH_WIDE_RUN_BIT    = 7;
  localparam int SH_CARRIER_RUN_BIT = 6;
  localparam int SH_SYNC_BIT        = 5;
  localparam int SH_FREEZE_BIT      = 4;
  localparam int SH_SINGLE_BIT      = 3;
  localparam logic [2:0] SH_RESERVED_ONES = 3'h7;

  // reset values
  localparam logic [7:0] WIDE_CTRL_RESET   = 8'h00;
  localparam logic [4:0] SHARED_CTRL_RESET = 5'h00;

  // single-cycle capture edge numbers
  localparam int ACTIVE_EDGE        = 3;
  localparam int FIRST_CAPTURE_EDGE = 4;
  localparam int LAST_CAPTURE_EDGE  = 5;

  // bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    DTC_DIV1 = 2'h0,
    DTC_DIV2 = 2'h1,
    DTC_DIV4 = 2'h2,
    DTC_DIV8 = 2'h3
  } dtc_prescale_type;

  typedef enum logic [2:0] {
    SYNC_IDLE = 3'h1,
    SYNC_WAIT = 3'h2,
    SYNC_RUN  = 3'h4
  } dtc_sync_type;

endpackage

// ---- rtl/dtc_prescaler.sv ----
/*
  dtc_prescaler: free-running divider that makes a one-cycle count
  enable at sys_clk divided by 1, 2, 4 or 8.
  Assumes the select is held by a register in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module dtc_prescaler #(
  parameter int DIV_WIDTH = 3
) (
  input  wire logic                 sys_clk,   // system clock
  input  wire logic                 rst_b,     // async reset, active low
  input  wire dtc_pkg::dtc_prescale_type sel,  // divide select
  output logic                      tickEn     // one-cycle count enable
);

  if (DIV_WIDTH < 3) begin
    $error("dtc_prescaler needs DIV_WIDTH of at least 3");
  end

  logic [DIV_WIDTH-1:0] count_reg;
  logic [DIV_WIDTH-1:0] count_next;
  logic [DIV_WIDTH-1:0] mask;
  logic                 tick_next;
  logic                 tick_reg;

  // the divider never stops, so a rate change takes effect on the next cycle without waiting for a wrap
  always_comb begin
    count_next = count_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    mask       = {DIV_WIDTH{1'b0}};
    case (sel)
      dtc_pkg::DTC_DIV1: mask = {DIV_WIDTH{1'b0}};
      dtc_pkg::DTC_DIV2: mask = {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      dtc_pkg::DTC_DIV4: mask = {{(DIV_WIDTH-2){1'b0}}, 2'h3};
      dtc_pkg::DTC_DIV8: mask = {{(DIV_WIDTH-3){1'b0}}, 3'h7};
      default:           mask = {DIV_WIDTH{1'b0}};
    endcase
    tick_next = &(count_next | ~mask);
  end

  // registered so the enable is a clean flop output
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= {DIV_WIDTH{1'b0}};
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tickEn = tick_reg;

endmodule

`default_nettype wire

// ---- sim/dtc_checker_sva.sv ----
/*
  dtc_checker: concurrent checks on the ports of the dual timer control.
  Assumes it is bound onto dtc_dual_timer_control and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dtc_checker #(
  parameter int COUNT_W = 3
) (
  input wire logic sys_clk,         // system clock
  input wire logic rst_b,           // async reset, active low
  input wire logic hreadyout,       // slave ready
  input wire logic hresp,           // response
  input wire logic timeoutEvent,    // wide terminal count pulse
  input wire logic captureEvent,    // wide capture pulse
  input wire logic demodMode,       // demodulation mode level
  input wire logic carrierCtlRun,   // carrier control run bit
  input wire logic carrierEdge,     // carrier input edge pulse
  input wire logic carrierTimeout,  // carrier time-out pulse
  input wire logic portDataLatch,   // ordinary port data
  input wire logic wideTimerRun,    // wide timer enabled
  input wire logic carrierTimerRun, // carrier timer enabled
  input wire logic wideCountEn,     // wide count enable pulse
  input wire logic wideTimerIrq,    // wide interrupt pulse
  input wire logic wideTimerOut,    // wide output level
  input wire logic port3Pin5,       // pin output level
  input wire logic carrierActive,   // carrier capture active
  input wire logic carrierCapture,  // carrier capture pulse
  input wire logic carrierIrq       // carrier interrupt pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // a time-out empties the edge count, so three edges are needed again
  sequence s_carrier_timeout;
    carrierTimeout;
  endsequence
  sequence s_count_cleared;
    !carrierActive [*3];
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_count_gate: assert property (!wideTimerRun |-> !wideCountEn)
    else $error("count enable while wide timer stopped");
  chk_carrier_either: assert property (carrierCtlRun |-> carrierTimerRun)
    else $error("carrier stopped while its control bit is set");
  chk_irq_cause: assert property (wideTimerIrq |->
      $past(timeoutEvent) || $past(captureEvent && demodMode))
    else $error("wide interrupt without a cause");
  chk_toggle_cause: assert property ($changed(wideTimerOut) |->
      $past(timeoutEvent && wideTimerRun))
    else $error("wide output moved without a running time-out");
  chk_pin_source: assert property (port3Pin5 == portDataLatch || port3Pin5 == wideTimerOut)
    else $error("pin shows neither source");
  chk_capture_edge: assert property (carrierCapture |-> $past(carrierEdge && carrierTimerRun))
    else $error("carrier capture without a taken edge");
  chk_irq_capture: assert property (carrierIrq |-> carrierCapture)
    else $error("carrier interrupt without capture");
  chk_timeout_clear: assert property (s_carrier_timeout |=> s_count_cleared)
    else $error("carrier still active after time-out");

endmodule

bind dtc_dual_timer_control dtc_checker #(.COUNT_W(COUNT_W)) u_checker (
  .sys_clk(sys_clk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
  .timeoutEvent(timeoutEvent), .captureEvent(captureEvent), .demodMode(demodMode),
  .carrierCtlRun(carrierCtlRun), .carrierEdge(carrierEdge), .carrierTimeout(carrierTimeout),
  .portDataLatch(portDataLatch), .wideTimerRun(wideTimerRun),
  .carrierTimerRun(carrierTimerRun), .wideCountEn(wideCountEn), .wideTimerIrq(wideTimerIrq),
  .wideTimerOut(wideTimerOut), .port3Pin5(port3Pin5), .carrierActive(carrierActive),
  .carrierCapture(carrierCapture), .carrierIrq(carrierIrq)
);

`default_nettype wire

// ---- sim/dual_timer_control_bench.sv ----
/*
  dual_timer_control_bench: self-checking bench for the dual timer control.
  Assumes a single AHB-Lite slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
`default_nettype none

module dual_timer_control_bench;
  logic        sys_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, rdPhase;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        stopRecovery, timeoutEvent, captureEvent, demodMode, carrierCtlRun;
  logic        carrierEdge, carrierTimeout, demodSignal, portDataLatch, singlePass;
  logic        wideTimerRun, carrierTimerRun, wideCountEn, wideTimerIrq, wideTimerOut;
  logic        port3Pin5, carrierGate, carrierActive, carrierCapture, carrierIrq;
  logic [31:0] expQ[$];
  int          failures, cmpCount, cycles, n;

  dtc_dual_timer_control #(.COUNT_W(3)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stopRecovery(stopRecovery),
    .timeoutEvent(timeoutEvent), .captureEvent(captureEvent), .demodMode(demodMode),
    .carrierCtlRun(carrierCtlRun), .carrierEdge(carrierEdge),
    .carrierTimeout(carrierTimeout), .demodSignal(demodSignal),
    .portDataLatch(portDataLatch), .wideTimerRun(wideTimerRun),
    .carrierTimerRun(carrierTimerRun), .wideCountEn(wideCountEn), .singlePass(singlePass),
    .wideTimerIrq(wideTimerIrq), .wideTimerOut(wideTimerOut), .port3Pin5(port3Pin5),
    .carrierGate(carrierGate), .carrierActive(carrierActive),
    .carrierCapture(carrierCapture), .carrierIrq(carrierIrq)
  );

  // the one slave's ready is the bus ready
  assign hready = hreadyout;

  // clock, 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("compared %0d, wrong %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; a read leaves its expected word in the queue
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] v);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= dtc_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? v : 32'h0;
    if (!wr) expQ.push_back(v);
    do @(posedge sys_clk); while (hready !== 1'b1);
  endtask

  // one-cycle event pulse; returns just after the edge that took it
  task automatic pulse(input int which);
    case (which)
      0: timeoutEvent <= 1'b1;
      1: captureEvent <= 1'b1;
      2: carrierEdge <= 1'b1;
      3: carrierTimeout <= 1'b1;
      default: stopRecovery <= 1'b1;
    endcase
    @(posedge sys_clk);
    {timeoutEvent, captureEvent, carrierEdge, carrierTimeout, stopRecovery} <= 5'h00;
    #1;
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge sys_clk) begin
    if (rdPhase) begin
      cmp(hrdata, expQ.pop_front());
    end
    rdPhase <= hsel && hready && htrans == dtc_pkg::HTRANS_NONSEQ && !hwrite;
  end

  // hang guard, well above the run's length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {stopRecovery, timeoutEvent, captureEvent, demodMode, carrierCtlRun} = 5'h00;
    {carrierEdge, carrierTimeout, demodSignal, portDataLatch} = 4'h0;
    hsize = 3'h2;
    failures = 0;
    cmpCount = 0;
    cycles = 0;
    d = $urandom(49);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, 32'h00);
    xfer(1'b0, dtc_pkg::SHARED_CTRL_ADDR, 32'h07);
    xfer(1'b1, dtc_pkg::STATUS_ADDR + 32'h4, 32'hFF);
    xfer(1'b0, dtc_pkg::STATUS_ADDR + 32'h4, 32'h00);
    $display("test done: reset values");
    // random words; upper bits and reserved bits must not stick
    for (n = 0; n < 8; n++) begin
      d = $urandom;
      xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, d);
      xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, {24'h0, d[7:6], 1'b0, d[4:0]});
      xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, d);
      xfer(1'b0, dtc_pkg::SHARED_CTRL_ADDR, {24'h0, d[7:3], 3'h7});
    end
    $display("test done: register round trip");
    for (n = 0; n < 16; n++) begin
      carrierCtlRun <= n[3];
      xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, {24'h0, n[0], 7'h0});
      xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, {24'h0, n[1], n[2], 6'h07});
      #1;
      cmpBit(wideTimerRun, n[0] | n[1]);
      cmpBit(carrierTimerRun, n[2] | n[3]);
    end
    carrierCtlRun <= 1'b0;
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'h00);
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h07);
    #1;
    cmp({30'h0, wideTimerRun, carrierTimerRun}, 32'h0);
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'hC7);
    #1;
    cmp({30'h0, wideTimerRun, carrierTimerRun}, 32'h3);
    $display("test done: enables");
    // count enables over 64 cycles for each divide select
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h07);
    for (n = 0; n < 4; n++) begin
      xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, {24'h0, 3'h4, n[1:0], 3'h0});
      repeat (3) @(posedge sys_clk);
      d = 32'h0;
      repeat (64) begin
        @(posedge sys_clk);
        #1 d = d + {31'h0, wideCountEn};
      end
      cmp(d, 32'h40 >> n);
    end
    $display("test done: prescale");
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'hDF);
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'hFF);
    pulse(4);
    cmpBit(singlePass, 1'b0);
    xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, 32'h1C);
    xfer(1'b0, dtc_pkg::SHARED_CTRL_ADDR, 32'h3F);
    $display("test done: stop recovery");
    // time-out with and without mask, then frozen output
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h07);
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'h83);
    pulse(0);
    cmpBit(wideTimerIrq, 1'b1);
    cmpBit(wideTimerOut, 1'b1);
    cmpBit(port3Pin5, 1'b1);
    xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, 32'hA3);
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'h81);
    xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, 32'hA1);
    pulse(0);
    cmpBit(wideTimerIrq, 1'b0);
    cmpBit(wideTimerOut, 1'b0);
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'hA3);
    xfer(1'b0, dtc_pkg::WIDE_CTRL_ADDR, 32'h83);
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h17);
    pulse(0);
    cmpBit(wideTimerIrq, 1'b1);
    cmpBit(wideTimerOut, 1'b0);
    demodMode <= 1'b1;
    portDataLatch <= 1'b1;
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'h84);
    pulse(1);
    cmpBit(wideTimerIrq, 1'b1);
    cmpBit(port3Pin5, 1'b1);
    xfer(1'b1, dtc_pkg::WIDE_CTRL_ADDR, 32'h80);
    pulse(1);
    cmpBit(wideTimerIrq, 1'b0);
    $display("test done: wide interrupts");
    // single-cycle capture twice, a time-out between the passes
    carrierCtlRun <= 1'b1;
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h0F);
    repeat (2) begin
      for (n = 1; n <= 5; n++) begin
        pulse(2);
        cmpBit(carrierActive, n >= 3);
        cmpBit(carrierCapture, n >= 4);
        cmpBit(carrierIrq, n == 5);
      end
      pulse(3);
      cmpBit(carrierActive, 1'b0);
    end
    carrierCtlRun <= 1'b0;
    repeat (3) @(posedge sys_clk); // idle after the time-out
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h47);
    pulse(2);
    cmpBit(carrierCapture, 1'b1);
    cmpBit(carrierIrq, 1'b1);
    $display("test done: carrier capture");
    // sync gate waits for a rise of the demodulated signal
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h67);
    repeat (3) @(posedge sys_clk);
    #1;
    cmpBit(carrierGate, 1'b0);
    demodSignal <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    cmpBit(carrierGate, 1'b1);
    demodSignal <= 1'b0;
    xfer(1'b1, dtc_pkg::SHARED_CTRL_ADDR, 32'h47);
    repeat (2) @(posedge sys_clk);
    #1;
    cmpBit(carrierGate, 1'b1);
    $display("test done: sync");
    give_verdict();
  end
endmodule

`default_nettype wire
